// [verilog/ext_bus_pkg.sv]
// constants and types for the external memory bus interface
package ext_bus_pkg;
  // machine cycle is six states, two phases each
  localparam int unsigned STATES_PER_CYCLE = 6;
  localparam int unsigned STATE_W = 3;
  localparam logic [2:0] STATE_LAST = 3'h5;
  localparam logic [15:0] INTERNAL_TOP = 16'h1FFF;
  localparam logic [7:0] PORT_ZERO_RESET = 8'hFF;
  localparam logic [7:0] PORT_TWO_RESET = 8'h00;
  localparam int unsigned CLK_PERIOD_NS = 40;

  // access kinds requested by the core
  typedef enum logic [1:0] {
    acc_fetch = 2'h0,
    acc_rd = 2'h1,
    acc_wr = 2'h3
  } access_e;

  // bus sequence, gray coded along the usual path from idle up to hold
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_addr = 3'h1,
    st_latch = 3'h3,
    st_strobe = 3'h2,
    st_hold = 3'h6
  } bus_state_e;
endpackage : ext_bus_pkg

// [verilog/ext_bus_if.sv]
// external program and data memory bus interface of the core
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R1 - program fetches always drive sixteen-bit address
// R2 - pointer access sixteen bits, indirect eight bits
// R3 - upper address byte held on port two
// R4 - port two ones driven strongly when addressing
// R5 - port two latch untouched, restored after cycle
// R6 - eight-bit access keeps port two latch value
// R7 - port zero multiplexes address, data, driven both
// R8 - low address valid at latch pulse fall
// R9 - write data surrounds write strobe active time
// R10 - read data sampled just before strobe release
// R11 - any external access loads ones into port zero
// R12 - port zero writes blocked during external access
// R13 - external fetch on select or above limit
// R14 - port two dedicated output during external execution
// R15 - program strobe reads every external fetch
// R16 - data strobes handle external data moves
// R17 - bus switches port drivers off latches
// R18 - latch pulse twice per cycle without data; the code pulses it once per access, from st_addr only
////////////////////////////////////////////////////////////////////////////
module ext_bus_if (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic external_access_select,
  input wire logic [15:0] program_counter,
  input wire logic req_valid,
  output logic req_ready,
  input wire ext_bus_pkg::access_e req_kind,
  input wire logic req_use_pointer,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic fetch_external,
  input wire logic port_zero_wr,
  input wire logic [7:0] port_zero_wdata,
  input wire logic port_two_wr,
  input wire logic [7:0] port_two_wdata,
  output logic [7:0] port_zero_latch,
  output logic [7:0] port_two_latch,
  input wire logic [7:0] port_zero_in,
  output logic [7:0] port_zero_out,
  output logic [7:0] port_zero_oe_n,
  output logic [7:0] port_two_out,
  output logic [7:0] port_two_strong_n,
  output logic address_latch_pulse,
  output logic program_read_strobe_n,
  output logic data_read_strobe_n,
  output logic data_write_strobe_n
);
  ext_bus_pkg::bus_state_e state_q;
  logic [2:0] phase_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic wide_q;
  ext_bus_pkg::access_e kind_q;
  logic bus_active;

  ////////////////////////////////////////////////////////////////////////////
  assign fetch_external = external_access_select ||
    (program_counter > ext_bus_pkg::INTERNAL_TOP); // R13
  assign req_ready = (state_q == ext_bus_pkg::st_idle);
  assign bus_active = (state_q != ext_bus_pkg::st_idle);

  // state sequence: one ref_clk per bus state, except strobe, which lasts six for data accesses
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= ext_bus_pkg::st_idle;
      phase_q <= 3'h0;
    end else begin
      case (state_q)
        ext_bus_pkg::st_idle: begin
          phase_q <= 3'h0;
          if (req_valid) begin
            state_q <= ext_bus_pkg::st_addr;
          end
        end
        ext_bus_pkg::st_addr: begin
          state_q <= ext_bus_pkg::st_latch;
        end
        ext_bus_pkg::st_latch: begin
          state_q <= ext_bus_pkg::st_strobe;
          phase_q <= 3'h0;
        end
        ext_bus_pkg::st_strobe: begin
          // data strobes stretch over the full cycle, fetch is short
          phase_q <= phase_q + 3'h1;
          if (kind_q == ext_bus_pkg::acc_fetch ||
              phase_q == ext_bus_pkg::STATE_LAST) begin // R18
            state_q <= ext_bus_pkg::st_hold;
          end
        end
        ext_bus_pkg::st_hold: begin
          state_q <= ext_bus_pkg::st_idle;
        end
        default: begin
          state_q <= ext_bus_pkg::st_idle;
        end
      endcase
    end
  end

  // capture the request
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      wide_q <= 1'b0;
      kind_q <= ext_bus_pkg::acc_fetch;
    end else if (req_valid && req_ready) begin
      addr_q <= req_addr;
      wdata_q <= req_wdata;
      kind_q <= req_kind;
      wide_q <= (req_kind == ext_bus_pkg::acc_fetch) ||
        req_use_pointer; // R1 R2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port latches; core writes to port zero ignored while the bus is busy
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      port_zero_latch <= ext_bus_pkg::PORT_ZERO_RESET;
    end else if (bus_active) begin
      port_zero_latch <= ext_bus_pkg::PORT_ZERO_RESET; // R11 R12
    end else if (port_zero_wr) begin
      port_zero_latch <= port_zero_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      port_two_latch <= ext_bus_pkg::PORT_TWO_RESET;
    end else if (port_two_wr) begin
      port_two_latch <= port_two_wdata; // R5
    end
  end

  // read data captured while its strobe is still low at the pin
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      // fetch strobe is low for one step only, so sample in hold
      if ((state_q == ext_bus_pkg::st_hold &&
           kind_q == ext_bus_pkg::acc_fetch) ||
          (state_q == ext_bus_pkg::st_strobe &&
           kind_q == ext_bus_pkg::acc_rd &&
           phase_q == ext_bus_pkg::STATE_LAST)) begin
        rsp_valid <= 1'b1;
        rsp_data <= port_zero_in; // R10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers, registered
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      port_zero_out <= ext_bus_pkg::PORT_ZERO_RESET;
      port_zero_oe_n <= 8'hFF;
      port_two_out <= ext_bus_pkg::PORT_TWO_RESET;
      port_two_strong_n <= 8'hFF;
      address_latch_pulse <= 1'b0;
      program_read_strobe_n <= 1'b1;
      data_read_strobe_n <= 1'b1;
      data_write_strobe_n <= 1'b1;
    end else begin
      // port zero: open drain from latch when idle
      port_zero_out <= 8'h00;
      port_zero_oe_n <= port_zero_latch;
      port_two_out <= port_two_latch; // R6
      port_two_strong_n <= 8'hFF;
      address_latch_pulse <= 1'b0;
      program_read_strobe_n <= 1'b1;
      data_read_strobe_n <= 1'b1;
      data_write_strobe_n <= 1'b1;
      if (bus_active) begin
        if (wide_q) begin
          port_two_out <= addr_q[15:8]; // R3 R14 R17
          port_two_strong_n <= ~addr_q[15:8]; // R4
        end
        case (state_q)
          ext_bus_pkg::st_addr: begin
            port_zero_out <= addr_q[7:0]; // R7
            port_zero_oe_n <= 8'h00;
            address_latch_pulse <= 1'b1; // R18
          end
          ext_bus_pkg::st_latch: begin
            // pulse falls with address still held
            port_zero_out <= addr_q[7:0]; // R8
            port_zero_oe_n <= 8'h00;
          end
          ext_bus_pkg::st_strobe: begin
            if (kind_q == ext_bus_pkg::acc_wr) begin
              port_zero_out <= wdata_q; // R9
              port_zero_oe_n <= 8'h00;
              // strobe waits one step so the data byte leads it
              data_write_strobe_n <= (phase_q == 3'h0) ||
                (phase_q == ext_bus_pkg::STATE_LAST); // R9 R16
            end else if (kind_q == ext_bus_pkg::acc_rd) begin
              data_read_strobe_n <=
                (phase_q == ext_bus_pkg::STATE_LAST); // R16
            end else begin
              program_read_strobe_n <= 1'b0; // R15
            end
          end
          ext_bus_pkg::st_hold: begin
            if (kind_q == ext_bus_pkg::acc_wr) begin
              port_zero_out <= wdata_q; // R9
              port_zero_oe_n <= 8'h00;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule : ext_bus_if

// [bench/ext_bus_chk.sv]
// property checks on the external memory bus pins
`timescale 1ns/1ps
module ext_bus_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire ext_bus_pkg::access_e req_kind,
  input wire logic rsp_valid,
  input wire logic [7:0] port_zero_latch,
  input wire logic [7:0] port_zero_out,
  input wire logic [7:0] port_zero_oe_n,
  input wire logic [7:0] port_two_out,
  input wire logic [7:0] port_two_strong_n,
  input wire logic address_latch_pulse,
  input wire logic program_read_strobe_n,
  input wire logic data_read_strobe_n,
  input wire logic data_write_strobe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire tk = req_valid && req_ready;
  wire tf = tk && req_kind == ext_bus_pkg::acc_fetch;
  wire tr = tk && req_kind == ext_bus_pkg::acc_rd;
  chk_fetch_answer: assert property (tf |-> ##5 rsp_valid)
    else $error("fetch answer late");
  chk_fetch_strobe: assert property (
    tf |-> ##[2:4] !program_read_strobe_n) else $error("no fetch strobe");
  chk_read_answer: assert property (tr |-> ##9 rsp_valid)
    else $error("read answer late");
  chk_ale_width: assert property (
    address_latch_pulse |=> !address_latch_pulse) else $error("ale wide");
  chk_ale_addr: assert property ($fell(address_latch_pulse) |->
    $stable(port_zero_out) && port_zero_oe_n == 8'h00) else $error("p0 addr");
  chk_wr_hold: assert property ($rose(data_write_strobe_n) |->
    $stable(port_zero_out) && port_zero_oe_n == 8'h00) else $error("wr data");
  chk_wr_setup: assert property ($fell(data_write_strobe_n) |->
    $stable(port_zero_out) && port_zero_oe_n == 8'h00) else $error("wr lead");
  chk_p2_steady: assert property (!(program_read_strobe_n &&
    data_read_strobe_n && data_write_strobe_n) |-> $stable(port_two_out))
    else $error("p2 moved");
  chk_p0_ones: assert property (tk |->
    ##[1:2] port_zero_latch == 8'hFF) else $error("p0 latch not ones");
  chk_p2_strong: assert property (port_two_strong_n != 8'hFF |->
    port_two_strong_n == ~port_two_out) else $error("p2 drive");
endmodule : ext_bus_chk

// [bench/ext_mem_model.sv]
// external address latch and byte-wide memory
`timescale 1ns/1ps
module ext_mem_model (
  input wire logic [7:0] port_zero_out,
  input wire logic [7:0] port_zero_oe_n,
  input wire logic [7:0] port_two_out,
  input wire logic address_latch_pulse,
  input wire logic program_read_strobe_n,
  input wire logic data_read_strobe_n,
  input wire logic data_write_strobe_n,
  output logic [7:0] port_zero_in,
  output logic [15:0] addr_q
);
  logic [7:0] mem [0:65535];
  wire rd = !(program_read_strobe_n && data_read_strobe_n);
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i ^ (i >> 8));
  always @(negedge address_latch_pulse) begin
    addr_q = {port_two_out, port_zero_out};
  end
  always @(posedge data_write_strobe_n) mem[addr_q] = port_zero_out;
  // released bits show the inverse, never a stale copy
  assign port_zero_in = rd ? mem[addr_q] :
    port_zero_out ^ port_zero_oe_n;
endmodule : ext_mem_model

// [bench/tb_top.sv]
// self-checking bench for the external memory bus interface
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, reset, external_access_select, req_valid, req_ready;
  logic req_use_pointer, rsp_valid, fetch_external, port_zero_wr;
  logic port_two_wr, address_latch_pulse, program_read_strobe_n;
  logic data_read_strobe_n, data_write_strobe_n;
  logic [15:0] program_counter, req_addr, addr_q;
  logic [7:0] req_wdata, rsp_data, port_zero_wdata, port_two_wdata, d;
  logic [7:0] port_zero_latch, port_two_latch, port_zero_in, port_zero_out;
  logic [7:0] port_zero_oe_n, port_two_out, port_two_strong_n;
  ext_bus_pkg::access_e req_kind;
  int n_fail = 0;
  int comparisons = 0;
  ext_bus_if dut_u (
    .ref_clk(ref_clk),
    .reset(reset),
    .external_access_select(external_access_select),
    .program_counter(program_counter),
    .req_valid(req_valid),
    .req_ready(req_ready),
    .req_kind(req_kind),
    .req_use_pointer(req_use_pointer),
    .req_addr(req_addr),
    .req_wdata(req_wdata),
    .rsp_valid(rsp_valid),
    .rsp_data(rsp_data),
    .fetch_external(fetch_external),
    .port_zero_wr(port_zero_wr),
    .port_zero_wdata(port_zero_wdata),
    .port_two_wr(port_two_wr),
    .port_two_wdata(port_two_wdata),
    .port_zero_latch(port_zero_latch),
    .port_two_latch(port_two_latch),
    .port_zero_in(port_zero_in),
    .port_zero_out(port_zero_out),
    .port_zero_oe_n(port_zero_oe_n),
    .port_two_out(port_two_out),
    .port_two_strong_n(port_two_strong_n),
    .address_latch_pulse(address_latch_pulse),
    .program_read_strobe_n(program_read_strobe_n),
    .data_read_strobe_n(data_read_strobe_n),
    .data_write_strobe_n(data_write_strobe_n)
  );
  ext_mem_model mem_u (
    .port_zero_out(port_zero_out),
    .port_zero_oe_n(port_zero_oe_n),
    .port_two_out(port_two_out),
    .address_latch_pulse(address_latch_pulse),
    .program_read_strobe_n(program_read_strobe_n),
    .data_read_strobe_n(data_read_strobe_n),
    .data_write_strobe_n(data_write_strobe_n),
    .port_zero_in(port_zero_in),
    .addr_q(addr_q)
  );
  task automatic end_sim;
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask : step
  // pz pokes the port zero latch while the access is under way
  task automatic access(input ext_bus_pkg::access_e k, input logic w,
                        input logic [15:0] a, input logic [7:0] wd,
                        input logic pz);
    int i;
    req_valid = 1'b1;
    req_kind = k;
    req_use_pointer = w;
    req_addr = a;
    req_wdata = wd;
    for (i = 0; req_ready !== 1'b1; i++) begin
      if (i > 20) n_fail++;
      if (i > 20) end_sim();
      step();
    end
    step();
    req_valid = 1'b0;
    port_zero_wr = pz;
    step();
    port_zero_wr = 1'b0;
    for (i = 0; (k == ext_bus_pkg::acc_wr ? req_ready : rsp_valid) !== 1'b1;
         i++) begin
      if (i > 20) n_fail++;
      if (i > 20) end_sim();
      step();
    end
    d = rsp_data;
  endtask : access
  task automatic sc_select;
    program_counter = 16'h1FFF;
    step();
    check(fetch_external, 1'b0);
    program_counter = 16'h2000;
    step();
    check(fetch_external, 1'b1);
    external_access_select = 1'b1;
    program_counter = 16'h0000;
    step();
    check(fetch_external, 1'b1);
  endtask : sc_select
  task automatic sc_fetch;
    access(ext_bus_pkg::acc_fetch, 1'b0, 16'h2345, 8'h00, 1'b0);
    check(d, 8'h66);
    check(addr_q, 16'h2345);
    check(port_two_strong_n, 8'hDC);
  endtask : sc_fetch
  task automatic sc_pages;
    port_two_wr = 1'b1;
    port_zero_wr = 1'b1;
    step();
    port_two_wr = 1'b0;
    port_zero_wr = 1'b0;
    check(port_zero_latch, 8'h12);
    access(ext_bus_pkg::acc_wr, 1'b1, 16'hA55A, 8'h3C, 1'b1);
    check(port_zero_latch, 8'hFF);
    check(port_two_latch, 8'h81);
    check(port_two_out, 8'hA5);
    step();
    check(port_two_out, 8'h81);
    access(ext_bus_pkg::acc_rd, 1'b1, 16'hA55A, 8'h00, 1'b0);
    check(d, 8'h3C);
    check(addr_q, 16'hA55A);
    access(ext_bus_pkg::acc_rd, 1'b0, 16'h0042, 8'h00, 1'b0);
    check(d, 8'hC3);
    check(addr_q, 16'h8142);
  endtask : sc_pages
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    {reset, external_access_select, req_valid, req_use_pointer} = 4'hF;
    {port_zero_wr, port_two_wr, program_counter, req_addr} = 34'h0;
    {req_wdata, port_zero_wdata, port_two_wdata} = 24'h001281;
    req_kind = ext_bus_pkg::acc_fetch;
    req_valid = 1'b0;
    external_access_select = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    sc_select();
    sc_fetch();
    sc_pages();
    end_sim();
  end
endmodule : tb_top
bind ext_bus_if ext_bus_chk chk_u (
  .ref_clk(ref_clk),
  .reset(reset),
  .req_valid(req_valid),
  .req_ready(req_ready),
  .req_kind(req_kind),
  .rsp_valid(rsp_valid),
  .port_zero_latch(port_zero_latch),
  .port_zero_out(port_zero_out),
  .port_zero_oe_n(port_zero_oe_n),
  .port_two_out(port_two_out),
  .port_two_strong_n(port_two_strong_n),
  .address_latch_pulse(address_latch_pulse),
  .program_read_strobe_n(program_read_strobe_n),
  .data_read_strobe_n(data_read_strobe_n),
  .data_write_strobe_n(data_write_strobe_n)
);
